// *** rtl/drm_defines.svh ***
`ifndef DRM_DEFINES_SVH
`define DRM_DEFINES_SVH

// Register byte offsets
`define DRM_OFS_CTRL 8'h00
`define DRM_OFS_STATUS 8'h04
`define DRM_OFS_MASK 8'h08
`define DRM_OFS_NETRX 8'h0c
`define DRM_OFS_CAL 8'h10
`define DRM_OFS_STATE 8'h14
`define DRM_OFS_NETTX 8'h18

// Field positions
`define DRM_CAL_START_BIT 0
`define DRM_CAL_FINISH_BIT 1
`define DRM_TX_PRESENT_BIT 31
`define DRM_TX_PROP_BIT 30
`define DRM_TX_FAULT_BIT 29

// Reset values
`define DRM_CTRL_RST 3'h0
`define DRM_MASK_RST 4'h0
`define DRM_NETRX_RST 19'h00000

// Identifier positions from this one upward select the output role
`define DRM_ID_FIRST_OUTPUT 3'h3

// Analogue limits in millivolts, one ADC code per millivolt
`define DRM_FAULT_MV 13'h0bb8
`define DRM_CAL_MIN_MV 13'h044c
`define DRM_CAL_NOM_MV 13'h04b0
`define DRM_CAL_MAX_MV 13'h0514

// Dead band on network x-y data before a direction relay closes
`define DRM_DEADBAND 8'h20

`endif

// *** rtl/drm_pkg.sv ***
package drm_pkg;

  typedef enum logic {
    ROLE_INPUT = 1'b0,
    ROLE_OUTPUT = 1'b1
  } drm_role_e;

  typedef enum logic [1:0] {
    CAL_IDLE = 2'b00,
    CAL_RUN = 2'b01,
    CAL_CHECK = 2'b10
  } drm_cal_e;

  typedef struct packed {
    logic horn;
    logic speedUp;
    logic speedDown;
    logic right;
    logic left;
    logic reverse;
    logic forward;
  } drm_relay_s;

  typedef struct packed {
    logic fifth;
    logic right;
    logic left;
    logic reverse;
    logic forward;
  } drm_switch_s;

  typedef struct packed {
    logic horn;
    logic speedDown;
    logic speedUp;
    logic signed [7:0] y;
    logic signed [7:0] x;
  } drm_netrx_s;

  typedef struct packed {
    logic ignoreDetect;
    logic diagonal;
    logic proportional;
  } drm_ctrl_s;

  typedef struct packed {
    logic calFail;
    logic calPass;
    logic detectLost;
    logic fault;
  } drm_status_s;

endpackage

// *** rtl/drm_axis_check.sv ***
`timescale 1ns/1ps
`include "drm_defines.svh"

module drm_axis_check (
  // Clock, enable and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // Samples in millivolts
  input wire logic [11:0] sample,
  input wire logic [11:0] refLevel,
  // Calibration control
  input wire logic calClear,
  input wire logic calRun,
  // Results
  output logic signed [12:0] deviation,
  output logic overLimit,
  output logic [12:0] peak
);

  logic [12:0] magnitude;
  logic [12:0] peak_ff;

  // Signed deviation from the reference and its magnitude
  assign deviation = $signed({1'b0, sample}) - $signed({1'b0, refLevel});
  assign magnitude = deviation[12] ? 13'(-deviation) : deviation;
  assign overLimit = magnitude > `DRM_FAULT_MV;
  assign peak = peak_ff;

  // Largest swing seen while calibrating
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      peak_ff <= 13'h0000;
    end else if (ce) begin
      if (calClear) begin
        peak_ff <= 13'h0000;
      end else if (calRun && magnitude > peak_ff) begin
        peak_ff <= magnitude;
      end
    end
  end

endmodule // drm_axis_check

// *** rtl/drm_io_mapper.sv ***
// Our own choices: register access over APB and the address map.
`timescale 1ns/1ps
`include "drm_defines.svh"

module drm_io_mapper (
  // Clock, enable and reset
  input wire logic mclk,
  input wire logic ce,
  input wire logic resetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Identifier strap
  input wire logic [2:0] idSwitch,
  // Input connector
  input wire drm_pkg::drm_switch_s switchPins,
  input wire logic detectN,
  input wire logic [11:0] speedAdc,
  input wire logic [11:0] dirAdc,
  input wire logic [11:0] refAdc,
  // System
  input wire logic chargerInhibit,
  // Network data and relay outputs
  output logic [31:0] netTx,
  output drm_pkg::drm_relay_s relayOut,
  output logic irq
);

  logic [1:0] rstSync_ff;
  logic rstn;
  logic idCaptured_ff;
  logic [2:0] idPos_ff;
  drm_pkg::drm_role_e role_ff;
  drm_pkg::drm_ctrl_s ctrl_ff;
  drm_pkg::drm_status_s status_ff;
  drm_pkg::drm_status_s nxt_status;
  logic [3:0] mask_ff;
  drm_pkg::drm_netrx_s netRx_ff;
  drm_pkg::drm_cal_e cal_ff;
  drm_pkg::drm_cal_e nxt_cal;
  drm_pkg::drm_relay_s relay_ff;
  drm_pkg::drm_relay_s nxt_relay;
  logic [31:0] netTx_ff;
  logic [31:0] nxt_netTx;
  logic faultLive_ff;
  logic present_ff;
  logic inhibitSeen_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  logic irq_ff;

  // Reset release through two flip-flops
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rstSync_ff <= 2'b00;
    end else begin
      rstSync_ff <= {rstSync_ff[0], 1'b1};
    end
  end
  assign rstn = rstSync_ff[1];

  // APB decode
  logic apbAccess;
  logic apbTake;
  logic apbDone;
  logic mapped;
  logic wrDone;
  logic rdStatusDone;
  logic [31:0] rdData;
  assign apbAccess = psel & penable;
  assign apbTake = apbAccess & ~pready_ff;
  assign apbDone = apbAccess & pready_ff;
  assign mapped = (paddr == `DRM_OFS_CTRL) | (paddr == `DRM_OFS_STATUS) |
                  (paddr == `DRM_OFS_MASK) | (paddr == `DRM_OFS_NETRX) |
                  (paddr == `DRM_OFS_CAL) | (paddr == `DRM_OFS_STATE) |
                  (paddr == `DRM_OFS_NETTX);
  assign wrDone = apbDone & pwrite & mapped;
  assign rdStatusDone = apbDone & ~pwrite & (paddr == `DRM_OFS_STATUS);

  // Read data selection
  assign rdData = (paddr == `DRM_OFS_CTRL) ? {29'h0, ctrl_ff} :
                  (paddr == `DRM_OFS_STATUS) ? {28'h0, status_ff} :
                  (paddr == `DRM_OFS_MASK) ? {28'h0, mask_ff} :
                  (paddr == `DRM_OFS_NETRX) ? {13'h0, netRx_ff} :
                  (paddr == `DRM_OFS_CAL) ? {30'h0, cal_ff} :
                  (paddr == `DRM_OFS_STATE) ? {18'h0, relay_ff, inhibitSeen_ff,
                                               faultLive_ff, present_ff, role_ff, idPos_ff} :
                  (paddr == `DRM_OFS_NETTX) ? netTx_ff : 32'h0000_0000;

  // Bus answer one cycle into the access phase
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else if (ce) begin
      pready_ff <= apbTake;
      pslverr_ff <= apbTake & ~mapped;
      if (apbTake && !pwrite) begin
        prdata_ff <= rdData;
      end
    end
  end

  // Software writable registers
  logic calStartWr;
  logic calFinishWr;
  assign calStartWr = wrDone & (paddr == `DRM_OFS_CAL) & pwdata[`DRM_CAL_START_BIT];
  assign calFinishWr = wrDone & (paddr == `DRM_OFS_CAL) & pwdata[`DRM_CAL_FINISH_BIT];
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctrl_ff <= `DRM_CTRL_RST;
      mask_ff <= `DRM_MASK_RST;
      netRx_ff <= `DRM_NETRX_RST;
    end else if (ce && wrDone) begin
      if (paddr == `DRM_OFS_CTRL) ctrl_ff <= pwdata[2:0];
      if (paddr == `DRM_OFS_MASK) mask_ff <= pwdata[3:0];
      if (paddr == `DRM_OFS_NETRX) netRx_ff <= pwdata[18:0];
    end
  end

  // Identifier strap caught once after reset release
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      idCaptured_ff <= 1'b0;
      idPos_ff <= 3'h0;
      role_ff <= drm_pkg::ROLE_INPUT;
    end else if (ce && !idCaptured_ff) begin
      idCaptured_ff <= 1'b1;
      idPos_ff <= idSwitch;
      role_ff <= (idSwitch >= `DRM_ID_FIRST_OUTPUT) ? drm_pkg::ROLE_OUTPUT
                                                    : drm_pkg::ROLE_INPUT;
    end
  end

  // Analogue channel checks
  logic signed [12:0] speedDev;
  logic signed [12:0] dirDev;
  logic speedOver;
  logic dirOver;
  logic [12:0] speedPeak;
  logic [12:0] dirPeak;
  drm_axis_check uSpeed (
    .clk(mclk),
    .rstn(rstn),
    .ce(ce),
    .sample(speedAdc),
    .refLevel(refAdc),
    .calClear(calStartWr),
    .calRun(cal_ff == drm_pkg::CAL_RUN),
    .deviation(speedDev),
    .overLimit(speedOver),
    .peak(speedPeak)
  );
  drm_axis_check uDir (
    .clk(mclk),
    .rstn(rstn),
    .ce(ce),
    .sample(dirAdc),
    .refLevel(refAdc),
    .calClear(calStartWr),
    .calRun(cal_ff == drm_pkg::CAL_RUN),
    .deviation(dirDev),
    .overLimit(dirOver),
    .peak(dirPeak)
  );

  // Presence, fault and input-role network data
  logic inputRole;
  logic present;
  logic faultNow;
  logic calInWindow;
  assign inputRole = idCaptured_ff & (role_ff == drm_pkg::ROLE_INPUT);
  assign present = ~detectN | ctrl_ff.ignoreDetect;
  assign faultNow = inputRole & ctrl_ff.proportional & present & (speedOver | dirOver);
  assign calInWindow = (speedPeak >= `DRM_CAL_MIN_MV) & (speedPeak <= `DRM_CAL_MAX_MV) &
                       (dirPeak >= `DRM_CAL_MIN_MV) & (dirPeak <= `DRM_CAL_MAX_MV);
  // Switched mode sends all five pins; proportional sends both deviations, or zero while a fault is flagged
  always_comb begin
    nxt_netTx = 32'h0000_0000;
    if (inputRole && present) begin
      nxt_netTx[`DRM_TX_PRESENT_BIT] = 1'b1;
      nxt_netTx[`DRM_TX_PROP_BIT] = ctrl_ff.proportional;
      nxt_netTx[`DRM_TX_FAULT_BIT] = faultNow;
      if (!ctrl_ff.proportional) begin
        nxt_netTx[4:0] = switchPins;
      end else if (!faultNow) begin
        nxt_netTx[25:0] = {dirDev, speedDev};
      end
    end
  end

  // Output-role direction decode
  logic [7:0] absX;
  logic [7:0] absY;
  logic xAct;
  logic yAct;
  logic yWins;
  drm_pkg::drm_relay_s dirs;
  assign absX = netRx_ff.x[7] ? 8'(-netRx_ff.x) : netRx_ff.x;
  assign absY = netRx_ff.y[7] ? 8'(-netRx_ff.y) : netRx_ff.y;
  assign xAct = absX > `DRM_DEADBAND;
  assign yAct = absY > `DRM_DEADBAND;
  assign yWins = ctrl_ff.diagonal | (absY >= absX);
  assign dirs.forward = yAct & yWins & ~netRx_ff.y[7];
  assign dirs.reverse = yAct & yWins & netRx_ff.y[7];
  assign dirs.right = xAct & (ctrl_ff.diagonal | ~(yAct & yWins)) & ~netRx_ff.x[7];
  assign dirs.left = xAct & (ctrl_ff.diagonal | ~(yAct & yWins)) & netRx_ff.x[7];
  assign dirs.speedUp = netRx_ff.speedUp;
  assign dirs.speedDown = netRx_ff.speedDown;
  assign dirs.horn = netRx_ff.horn;
  // Relays open outside the output role; inhibit plays no part
  assign nxt_relay = (idCaptured_ff && role_ff == drm_pkg::ROLE_OUTPUT) ? dirs
                                                                       : '0;

  // Calibration sequence
  always_comb begin
    case (cal_ff)
      drm_pkg::CAL_IDLE: nxt_cal = calStartWr ? drm_pkg::CAL_RUN : drm_pkg::CAL_IDLE;
      drm_pkg::CAL_RUN: nxt_cal = calFinishWr ? drm_pkg::CAL_CHECK : drm_pkg::CAL_RUN;
      drm_pkg::CAL_CHECK: nxt_cal = drm_pkg::CAL_IDLE;
      default: nxt_cal = drm_pkg::CAL_IDLE;
    endcase
  end

  // Sticky status: a read clears only the bits it returned, so a late event survives
  always_comb begin
    nxt_status = rdStatusDone ? (status_ff & ~prdata_ff[3:0]) : status_ff;
    nxt_status.fault = nxt_status.fault | (faultNow & ~faultLive_ff);
    nxt_status.detectLost = nxt_status.detectLost | (inputRole & present_ff & ~present);
    nxt_status.calPass = nxt_status.calPass | ((cal_ff == drm_pkg::CAL_CHECK) & calInWindow);
    nxt_status.calFail = nxt_status.calFail | ((cal_ff == drm_pkg::CAL_CHECK) & ~calInWindow);
  end

  // Block state
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cal_ff <= drm_pkg::CAL_IDLE;
      status_ff <= '0;
      relay_ff <= '0;
      netTx_ff <= 32'h0000_0000;
      faultLive_ff <= 1'b0;
      present_ff <= 1'b0;
      inhibitSeen_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else if (ce) begin
      cal_ff <= nxt_cal;
      status_ff <= nxt_status;
      relay_ff <= nxt_relay;
      netTx_ff <= nxt_netTx;
      faultLive_ff <= faultNow;
      present_ff <= inputRole & present;
      inhibitSeen_ff <= chargerInhibit;
      irq_ff <= |(nxt_status & mask_ff);
    end
  end

  // Outputs straight from flip-flops
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign netTx = netTx_ff;
  assign relayOut = relay_ff;
  assign irq = irq_ff;

  // Checks
  a_id_role: assert property (@(posedge mclk) disable iff (!rstn)
    idCaptured_ff |-> (role_ff == drm_pkg::ROLE_OUTPUT) == (idPos_ff >= 3'h3))
    else $error("role does not match identifier");
  a_fourway_single: assert property (@(posedge mclk) disable iff (!rstn)
    ($past(ce) && !$past(ctrl_ff.diagonal)) |-> $onehot0(relay_ff[3:0]))
    else $error("four-way closed more than one direction");
  a_diag_adjacent: assert property (@(posedge mclk) disable iff (!rstn)
    !(relay_ff.forward && relay_ff.reverse) && !(relay_ff.left && relay_ff.right))
    else $error("opposite directions closed together");
  a_buttons_follow: assert property (@(posedge mclk) disable iff (!rstn)
    (ce && idCaptured_ff && role_ff == drm_pkg::ROLE_OUTPUT) |=>
      {relay_ff.horn, relay_ff.speedUp, relay_ff.speedDown} ==
      $past({netRx_ff.horn, netRx_ff.speedUp, netRx_ff.speedDown}))
    else $error("button relays do not follow focus buttons");
  a_inhibit_ignored: assert property (@(posedge mclk) disable iff (!rstn)
    (ce && chargerInhibit && role_ff == drm_pkg::ROLE_OUTPUT && idCaptured_ff) |=>
      relay_ff == $past(dirs))
    else $error("charger inhibit gated a relay");
  a_fault_window: assert property (@(posedge mclk) disable iff (!rstn)
    (ce && faultNow) |=> (faultLive_ff && netTx_ff[25:0] == 26'h0 &&
      (status_ff.fault || $past(faultLive_ff))))
    else $error("swing beyond limit did not raise fault");
  a_switch_live: assert property (@(posedge mclk) disable iff (!rstn)
    (ce && inputRole && present && !ctrl_ff.proportional) |=>
      netTx_ff[4:0] == $past(switchPins))
    else $error("switch state not sent live");
  a_cal_result: assert property (@(posedge mclk) disable iff (!rstn)
    (ce && cal_ff == drm_pkg::CAL_CHECK) |=> (status_ff.calPass == $past(calInWindow)) ||
      $past(status_ff.calPass))
    else $error("calibration window judged wrongly");
  a_input_open: assert property (@(posedge mclk) disable iff (!rstn)
    ($past(ce) && $past(inputRole)) |-> relay_ff == '0)
    else $error("relay closed in input role");
  a_detect_absent: assert property (@(posedge mclk) disable iff (!rstn)
    (ce && detectN && !ctrl_ff.ignoreDetect) |=> !netTx_ff[31])
    else $error("absent device reported present");

endmodule // drm_io_mapper

// *** tb/drm_input_model.sv ***
`timescale 1ns/1ps
module drm_input_model (
  // Commands from the bench
  input wire logic prop,
  input wire logic linked,
  input wire drm_pkg::drm_switch_s pressed,
  input wire logic [11:0] speedMv,
  input wire logic [11:0] dirMv,
  input wire logic [11:0] refMv,
  // Connector pins
  output drm_pkg::drm_switch_s switchPins,
  output logic detectN,
  output logic [11:0] speedAdc,
  output logic [11:0] dirAdc,
  output logic [11:0] refAdc
);
  // Detect tied to ground while linked, pulled up when the link is absent
  assign detectN = linked ? 1'b0 : 1'b1;
  // Pins carry switches or analogue levels by input type
  assign switchPins = prop ? 5'h00 : pressed;
  assign speedAdc = prop ? speedMv : 12'h000;
  assign dirAdc = prop ? dirMv : 12'h000;
  assign refAdc = prop ? refMv : 12'h000;
endmodule // drm_input_model

// *** tb/tb_direction_relay_io_mapper.sv ***
`timescale 1ns/1ps
module tb_direction_relay_io_mapper;
  typedef struct packed {
    logic [2:0] ctrl;
    logic [31:0] netrx;
    logic [6:0] relay;
  } drm_row_s;
  logic mclk, ce, resetn, psel, penable, pwrite, pready, pslverr, detectN, chargerInhibit, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, netTx, rdat;
  logic [2:0] idSwitch;
  logic [11:0] speedAdc, dirAdc, refAdc, speedMv, dirMv, refMv;
  logic prop, linked, rerr;
  drm_pkg::drm_switch_s switchPins, pressed;
  drm_pkg::drm_relay_s relayOut;
  int error_cnt = 0;
  int checked = 0;
  int cycles = 0;
  // Relay rows: control, network word, expected relays
  drm_row_s rows [12] = '{
    '{3'h0, 32'h00004000, 7'h01}, '{3'h0, 32'h0000c000, 7'h02},
    '{3'h0, 32'h00002840, 7'h08}, '{3'h0, 32'h0000c0c0, 7'h02},
    '{3'h0, 32'h00000ac4, 7'h04}, '{3'h0, 32'h00002020, 7'h00},
    '{3'h0, 32'h00002100, 7'h01}, '{3'h2, 32'h000040c0, 7'h05},
    '{3'h2, 32'h0000ce32, 7'h0a}, '{3'h2, 32'h0000400a, 7'h01},
    '{3'h0, 32'h00070000, 7'h70}, '{3'h2, 32'h00010000, 7'h20}};

  drm_io_mapper i_dut (.mclk(mclk), .ce(ce), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .idSwitch(idSwitch), .switchPins(switchPins), .detectN(detectN),
    .speedAdc(speedAdc), .dirAdc(dirAdc), .refAdc(refAdc), .chargerInhibit(chargerInhibit),
    .netTx(netTx), .relayOut(relayOut), .irq(irq));

  drm_input_model i_dev (.prop(prop), .linked(linked), .pressed(pressed), .speedMv(speedMv),
    .dirMv(dirMv), .refMv(refMv), .switchPins(switchPins), .detectN(detectN),
    .speedAdc(speedAdc), .dirAdc(dirAdc), .refAdc(refAdc));

  // Clock and hang guard
  always #2.5 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      $display("ERROR at %0t: timeout", $time);
      stop_test();
    end
  end

  task stop_test;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task waitClk(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // One APB transfer, held until pready is sampled high
  task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask

  task rd(input logic [7:0] a);
    apb(a, 1'b0, 32'h00000000);
  endtask

  task doReset(input logic [2:0] id);
    resetn <= 1'b0;
    idSwitch <= id;
    waitClk(10);
    resetn <= 1'b1;
    waitClk(5);
  endtask

  // Main sequence
  initial begin
    mclk = 0; resetn = 0; ce = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    idSwitch = 0; chargerInhibit = 0; prop = 0; linked = 1; pressed = 0;
    speedMv = 0; dirMv = 0; refMv = 0;
    for (int i = 0; i < 8; i++) begin
      doReset(i[2:0]);
      rd(8'h14);
      chk(32'(rdat[3:0]), 32'({i >= 3, i[2:0]}), "role");
    end
    rd(8'h00);
    chk(rdat, 32'h0, "ctrl reset");
    rd(8'h08);
    chk(rdat, 32'h0, "mask reset");
    rd(8'h0c);
    chk(rdat, 32'h0, "netrx reset");
    rd(8'h1c);
    chk({rdat[30:0], rerr}, 32'h1, "unmapped");
    $display("test ids done");
    for (int r = 0; r < 12; r++) begin
      chargerInhibit <= r[0];
      wr(8'h00, 32'(rows[r].ctrl));
      wr(8'h0c, rows[r].netrx);
      waitClk(2);
      chk(32'(relayOut), 32'(rows[r].relay), "relay");
    end
    rd(8'h14);
    chk(32'(rdat[13:6]), 32'({7'h20, 1'b1}), "state relays");
    $display("test relays done");
    doReset(3'h0);
    wr(8'h0c, 32'h00074000);
    waitClk(2);
    chk(32'(relayOut), 32'h0, "input role relays");
    for (int p = 0; p < 32; p++) begin
      pressed <= p[4:0];
      waitClk(3);
      chk(32'({netTx[31:29], netTx[4:0]}), 32'({3'h4, p[4:0]}), "switches");
    end
    ce <= 1'b0;
    pressed <= 5'h15;
    waitClk(3);
    chk(32'(netTx[4:0]), 32'h1f, "frozen by enable");
    ce <= 1'b1;
    waitClk(3);
    chk(32'(netTx[4:0]), 32'h15, "enable resumes");
    $display("test switched done");
    wr(8'h00, 32'h1);
    prop <= 1; refMv <= 12'd2048; speedMv <= 12'd3048; dirMv <= 12'd1548;
    waitClk(3);
    chk({netTx[31:29], 3'h0, netTx[25:0]}, {6'h30, 13'h1e0c, 13'h03e8}, "prop");
    rd(8'h18);
    chk(rdat, {6'h30, 13'h1e0c, 13'h03e8}, "nettx reg");
    wr(8'h08, 32'h1);
    refMv <= 12'd500; speedMv <= 12'd3500; dirMv <= 12'd500;
    waitClk(3);
    chk(32'({netTx[29], irq}), 32'h0, "fault edge");
    speedMv <= 12'd3501;
    waitClk(3);
    chk(32'({netTx[29], irq}), 32'h3, "fault");
    rd(8'h04);
    chk(rdat, 32'h1, "fault status");
    waitClk(2);
    chk(32'(irq), 32'h0, "irq clear");
    speedMv <= 12'd500;
    wr(8'h08, 32'h2);
    linked <= 0;
    waitClk(3);
    chk(32'({netTx[31], irq}), 32'h1, "detect lost");
    rd(8'h04);
    chk(rdat, 32'h2, "lost status");
    wr(8'h00, 32'h5);
    waitClk(3);
    chk(32'(netTx[31]), 32'h1, "ignore detect");
    $display("test proportional done");
    linked <= 1; refMv <= 12'd2048; speedMv <= 12'd2048; dirMv <= 12'd2048;
    wr(8'h00, 32'h1);
    for (int c = 0; c < 2; c++) begin
      wr(8'h10, 32'h1);
      speedMv <= c ? 12'd3349 : 12'd3148;
      dirMv <= c ? 12'd3248 : 12'd3348;
      waitClk(4);
      speedMv <= 12'd2048; dirMv <= 12'd2048;
      wr(8'h10, 32'h2);
      waitClk(4);
      chk(32'(irq), 32'h0, "masked event");
      rd(8'h04);
      chk(rdat, c ? 32'h8 : 32'h4, "calibration");
    end
    $display("test calibration done");
    stop_test();
  end
endmodule // tb_direction_relay_io_mapper
